// File: design/dsoc_regs.svh
`ifndef DSOC_REGS_SVH
`define DSOC_REGS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define DSOC_ADDR_CTRL 8'h00
`define DSOC_ADDR_STATUS 8'h04
`define DSOC_ADDR_IRQ_STATUS 8'h08
`define DSOC_ADDR_IRQ_MASK 8'h0C
`define DSOC_ADDR_WORD_COUNT 8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define DSOC_CTRL_FORCE_SLEEP 0
`define DSOC_STAT_LOCKED 0
`define DSOC_STAT_SLEEPING 1
`define DSOC_STAT_OUT_ENABLED 2
`define DSOC_STAT_EDGE_RISING 3
`define DSOC_IRQ_LOCK_GAINED 0
`define DSOC_IRQ_LOCK_LOST 1
`define DSOC_IRQ_SLEEP_ENTERED 2
`define DSOC_IRQ_WIDTH 3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define DSOC_CTRL_RESET 32'h0000_0000
`define DSOC_IRQ_MASK_RESET 3'h0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define DSOC_CLK_MHZ 10
`define DSOC_LOCK_SETTLE_NS 1000
`define DSOC_LOCK_SETTLE_CYC \
  ((`DSOC_LOCK_SETTLE_NS * `DSOC_CLK_MHZ + 999) / 1000)

`endif

// File: design/dsoc_pkg.sv
package dsoc_pkg;

  typedef enum logic [2:0] {
    DSOC_ST_SLEEP = 3'b001,
    DSOC_ST_ACQUIRE = 3'b010,
    DSOC_ST_LOCKED = 3'b100
  } dsoc_state_type;

  // Parallel side pads: value, and enable that is low while driving.
  typedef struct packed {
    logic [9:0] word;
    logic word_oe_n;
    logic clock;
    logic clock_oe_n;
    logic lock_n;
    logic lock_oe_n;
  } dsoc_pads_type;

  typedef struct packed {
    logic tdi;
    logic tms;
    logic trst_n;
  } dsoc_tap_type;

endpackage

// File: design/dsoc_lock_qualifier.sv
`timescale 1ns/1ps
module dsoc_lock_qualifier #(
  parameter int SETTLE = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic raw_lock,
  output logic qualified
);

  logic [7:0] count;

  // Loss of the raw indication drops the result at once; only gaining
  // lock is filtered, so a glitching detector cannot flash the output.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
      qualified <= 1'b0;
    end else if (ce) begin
      if (clear || !raw_lock) begin
        count <= 8'h00;
        qualified <= 1'b0;
      end else if (count == 8'(SETTLE - 1)) begin
        qualified <= 1'b1;
      end else begin
        count <= count + 8'h01;
      end
    end
  end

endmodule

// File: design/dsoc_output_control.sv
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "dsoc_regs.svh"
module dsoc_output_control
  import dsoc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sleep_request_n,
  input wire logic output_enable_n,
  input wire logic recovered_edge_select,
  input wire logic pll_reference_clock,
  input wire logic pll_lock_detect,
  input wire logic word_strobe,
  input wire logic [9:0] word_in,
  input wire logic [2:0] tap_in,
  input wire logic [2:0] tap_driven,
  output dsoc_pads_type pads,
  output dsoc_tap_type tap,
  output logic pll_enable,
  output logic pll_reference_gated,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam int SETTLE = `DSOC_LOCK_SETTLE_CYC;

  dsoc_state_type state;
  dsoc_state_type next_state;
  logic [31:0] ctrl;
  logic [`DSOC_IRQ_WIDTH-1:0] irq_status;
  logic [`DSOC_IRQ_WIDTH-1:0] irq_mask;
  logic [`DSOC_IRQ_WIDTH-1:0] irq_events;
  logic [31:0] word_count;
  logic awake;
  logic qualified;
  logic locked;
  logic accept_word;
  logic [9:0] word_out;
  logic strobe_clock;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic do_read;
  logic clear_irq_on_read;
  logic [31:0] read_value;
  logic read_ok;

  // ----------------------------------------------------------------------
  // Lock tracking
  // ----------------------------------------------------------------------
  assign awake = sleep_request_n && !ctrl[`DSOC_CTRL_FORCE_SLEEP];
  assign pll_enable = awake;
  // The reference only reaches the PLL while it runs, saving its power.
  assign pll_reference_gated = pll_reference_clock && awake;

  dsoc_lock_qualifier #(
    .SETTLE(SETTLE)
  ) u_qualifier (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .clear(!awake),
    .raw_lock(pll_lock_detect),
    .qualified(qualified)
  );

  always_comb begin
    next_state = state;
    case (state)
      DSOC_ST_SLEEP: begin
        if (awake) begin
          next_state = DSOC_ST_ACQUIRE;
        end
      end
      DSOC_ST_ACQUIRE: begin
        if (!awake) begin
          next_state = DSOC_ST_SLEEP;
        end else if (qualified && pll_lock_detect) begin
          next_state = DSOC_ST_LOCKED;
        end
      end
      DSOC_ST_LOCKED: begin
        if (!awake) begin
          next_state = DSOC_ST_SLEEP;
        end else if (!pll_lock_detect) begin
          next_state = DSOC_ST_ACQUIRE;
        end
      end
      default: begin
        next_state = DSOC_ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DSOC_ST_SLEEP;
    end else if (ce) begin
      state <= next_state;
    end
  end

  assign locked = (state == DSOC_ST_LOCKED);

  // ----------------------------------------------------------------------
  // Output pads
  // ----------------------------------------------------------------------
  // Words arriving while unlocked are dropped; they cannot be trusted.
  assign accept_word = word_strobe && locked;

  // Data change with the clock at its idle level and the chosen edge
  // follows one cycle later, so strobes must be two cycles apart.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_out <= 10'h000;
      strobe_clock <= 1'b0;
    end else if (ce && locked) begin
      if (accept_word) begin
        word_out <= word_in;
        strobe_clock <= !recovered_edge_select;
      end else begin
        strobe_clock <= recovered_edge_select;
      end
    end
  end

  // One process drives the whole pad bundle, so it has a single driver.
  always_comb begin
    pads.word = word_out;
    pads.clock = strobe_clock;
    pads.lock_n = !locked;
    pads.lock_oe_n = (state == DSOC_ST_SLEEP);
    pads.word_oe_n = output_enable_n || !locked;
    pads.clock_oe_n = output_enable_n || !locked;
  end

  // ----------------------------------------------------------------------
  // Scan port defaults
  // ----------------------------------------------------------------------
  always_comb begin
    tap.tdi = tap_driven[0] ? tap_in[0] : 1'b1;
    tap.tms = tap_driven[1] ? tap_in[1] : 1'b1;
    tap.trst_n = tap_driven[2] ? tap_in[2] : 1'b1;
  end

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bresp = 2'b00;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `DSOC_CTRL_RESET;
      irq_mask <= `DSOC_IRQ_MASK_RESET;
    end else if (ce && do_write) begin
      if (aw_addr == `DSOC_ADDR_CTRL) begin
        if (w_strb[0]) begin
          ctrl[`DSOC_CTRL_FORCE_SLEEP] <= w_data[`DSOC_CTRL_FORCE_SLEEP];
        end
      end else if (aw_addr == `DSOC_ADDR_IRQ_MASK) begin
        if (w_strb[0]) begin
          irq_mask <= w_data[`DSOC_IRQ_WIDTH-1:0];
        end
      end
    end
  end

  always_comb begin
    read_value = 32'h0000_0000;
    read_ok = 1'b1;
    if (s_axi_araddr == `DSOC_ADDR_CTRL) begin
      read_value = ctrl;
    end else if (s_axi_araddr == `DSOC_ADDR_STATUS) begin
      read_value[`DSOC_STAT_LOCKED] = locked;
      read_value[`DSOC_STAT_SLEEPING] = (state == DSOC_ST_SLEEP);
      read_value[`DSOC_STAT_OUT_ENABLED] = !pads.word_oe_n;
      read_value[`DSOC_STAT_EDGE_RISING] = recovered_edge_select;
    end else if (s_axi_araddr == `DSOC_ADDR_IRQ_STATUS) begin
      read_value[`DSOC_IRQ_WIDTH-1:0] = irq_status;
    end else if (s_axi_araddr == `DSOC_ADDR_IRQ_MASK) begin
      read_value[`DSOC_IRQ_WIDTH-1:0] = irq_mask;
    end else if (s_axi_araddr == `DSOC_ADDR_WORD_COUNT) begin
      read_value = word_count;
    end else begin
      read_ok = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (ce) begin
      if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= read_value;
        s_axi_rresp <= read_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------------
  assign clear_irq_on_read = do_read &&
    (s_axi_araddr == `DSOC_ADDR_IRQ_STATUS);

  always_comb begin
    irq_events = '0;
    irq_events[`DSOC_IRQ_LOCK_GAINED] = !locked &&
      (next_state == DSOC_ST_LOCKED);
    irq_events[`DSOC_IRQ_LOCK_LOST] = locked &&
      (next_state == DSOC_ST_ACQUIRE);
    irq_events[`DSOC_IRQ_SLEEP_ENTERED] = (state != DSOC_ST_SLEEP) &&
      (next_state == DSOC_ST_SLEEP);
  end

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
    end else if (ce) begin
      irq_status <= (clear_irq_on_read ? '0 : irq_status) | irq_events;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(((clear_irq_on_read ? '0 : irq_status) | irq_events) &
        irq_mask);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_count <= 32'h0000_0000;
    end else if (ce && accept_word) begin
      word_count <= word_count + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_sleep_floats;
    @(posedge clk) disable iff (!rst_n)
    (!sleep_request_n && ce) |-> (!pll_enable && !pll_reference_gated) ##1
      (pads.lock_oe_n && pads.word_oe_n && pads.clock_oe_n);
  endproperty
  a_sleep_floats: assert property (p_sleep_floats)
    else $error("Outputs not floating in sleep.");

  property p_lock_low;
    @(posedge clk) disable iff (!rst_n)
    (ce && awake && state == DSOC_ST_ACQUIRE && qualified &&
      pll_lock_detect) |=> !pads.lock_n;
  endproperty
  a_lock_low: assert property (p_lock_low)
    else $error("Lock indicator did not go low on lock.");

  property p_strobe_clock;
    @(posedge clk) disable iff (!rst_n)
    (accept_word && ce) ##1 (ce && locked && !accept_word) |=>
      (pads.clock == recovered_edge_select);
  endproperty
  a_strobe_clock: assert property (p_strobe_clock)
    else $error("Recovered clock edge missing after word.");

  property p_disable_floats;
    @(posedge clk) disable iff (!rst_n)
    output_enable_n |-> (pads.word_oe_n && pads.clock_oe_n);
  endproperty
  a_disable_floats: assert property (p_disable_floats)
    else $error("Data or clock driven while disabled.");

  property p_lock_reported;
    @(posedge clk) disable iff (!rst_n)
    (state != DSOC_ST_SLEEP) |-> (!pads.lock_oe_n &&
      pads.lock_n == !locked);
  endproperty
  a_lock_reported: assert property (p_lock_reported)
    else $error("Lock indicator not reporting while awake.");

  property p_clock_still;
    @(posedge clk) disable iff (!rst_n)
    (!locked && $past(!locked)) |-> $stable(pads.clock);
  endproperty
  a_clock_still: assert property (p_clock_still)
    else $error("Recovered clock moved while unlocked.");

  property p_idle_phase;
    @(posedge clk) disable iff (!rst_n)
    (accept_word && ce) |=> (pads.clock != recovered_edge_select &&
      pads.word == $past(word_in));
  endproperty
  a_idle_phase: assert property (p_idle_phase)
    else $error("Data not set up at idle clock level.");

  property p_unlocked_floats;
    @(posedge clk) disable iff (!rst_n)
    pads.lock_n |-> (pads.word_oe_n && pads.clock_oe_n);
  endproperty
  a_unlocked_floats: assert property (p_unlocked_floats)
    else $error("Outputs driven while unlocked.");

  property p_pullup;
    @(posedge clk) disable iff (!rst_n)
    (tap_driven == 3'b000) |-> (tap == 3'b111);
  endproperty
  a_pullup: assert property (p_pullup)
    else $error("Undriven scan input not high.");

  property p_loss;
    @(posedge clk) disable iff (!rst_n)
    (locked && ce && awake && !pll_lock_detect) |=>
      (pads.lock_n && pads.word_oe_n);
  endproperty
  a_loss: assert property (p_loss)
    else $error("Lock loss not reported.");

  c_lock: cover property (@(posedge clk) disable iff (!rst_n)
    $fell(pads.lock_n));
  c_word: cover property (@(posedge clk) disable iff (!rst_n)
    accept_word && !output_enable_n);
  c_relock: cover property (@(posedge clk) disable iff (!rst_n)
    irq_status[`DSOC_IRQ_LOCK_LOST] && locked);

endmodule

// File: verif/dsoc_downstream_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Downstream capture register
// ----------------------------------------------------------------------
module dsoc_downstream_model
  import dsoc_pkg::*;
(
  input wire dsoc_pads_type pads,
  input wire logic recovered_edge_select,
  output logic [9:0] captured,
  output logic [15:0] captures
);
  initial begin
    captured = 10'h000;
    captures = 16'h0000;
  end

  // A floating clock pad is not trusted as a strobe.
  always @(posedge pads.clock) begin
    if (recovered_edge_select && !pads.clock_oe_n) begin
      captured = pads.word;
      captures = captures + 16'h0001;
    end
  end

  always @(negedge pads.clock) begin
    if (!recovered_edge_select && !pads.clock_oe_n) begin
      captured = pads.word;
      captures = captures + 16'h0001;
    end
  end
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
`include "dsoc_regs.svh"
module tb
  import dsoc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic sleep_request_n = 1'b1;
  logic output_enable_n = 1'b0;
  logic recovered_edge_select = 1'b1;
  logic pll_reference_clock = 1'b0;
  logic pll_lock_detect = 1'b0;
  logic word_strobe = 1'b0;
  logic [9:0] word_in = 10'h000;
  logic [2:0] tap_in = 3'h0;
  logic [2:0] tap_driven = 3'h0;
  dsoc_pads_type pads;
  dsoc_tap_type tap;
  logic pll_enable;
  logic pll_reference_gated;
  logic irq;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [9:0] captured;
  logic [31:0] rd;
  logic [1:0] rsp;
  logic [1:0] wrsp;
  logic last_clk;
  int failures = 0;
  int compares = 0;
  int n;

  always #50 clk = ~clk;
  always @(posedge clk) pll_reference_clock <= ~pll_reference_clock;

  dsoc_output_control u_dsoc_output_control (
    .clk, .rst_n, .ce, .sleep_request_n, .output_enable_n,
    .recovered_edge_select, .pll_reference_clock, .pll_lock_detect,
    .word_strobe, .word_in, .tap_in, .tap_driven, .pads, .tap,
    .pll_enable, .pll_reference_gated, .irq,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );

  dsoc_downstream_model u_dsoc_downstream_model (
    .pads,
    .recovered_edge_select,
    .captured,
    .captures()
  );

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wrsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic send_word(input logic [9:0] w);
    @(posedge clk);
    word_strobe <= 1'b1;
    word_in <= w;
    @(posedge clk);
    word_strobe <= 1'b0;
    @(negedge clk);
    check("word", pads.word, w);
    check("clock idle", pads.clock, !recovered_edge_select);
    @(negedge clk);
    check("clock active", pads.clock, recovered_edge_select);
    check("captured", captured, w);
  endtask

  // A slow lock is tolerated up to a bound, then reported.
  task automatic wait_lock;
    n = 0;
    while (pads.lock_n !== 1'b0 && n < 30) begin
      @(negedge clk);
      n++;
    end
    check("lock", pads.lock_n, 1'b0);
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("reset pads", {pads.word_oe_n, pads.clock_oe_n, irq}, 3'b110);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(negedge clk);
    check("acquire", {pads.lock_oe_n, pads.lock_n, pads.word_oe_n,
      pads.clock_oe_n}, 4'b0111);
    axi_read(`DSOC_ADDR_CTRL);
    check("ctrl reset", rd, `DSOC_CTRL_RESET);
    axi_read(`DSOC_ADDR_IRQ_MASK);
    check("mask reset", rd, 32'h0000_0000);
    axi_read(8'h20);
    check("unmapped resp", rsp, 2'b10);
    check("unmapped data", rd, 32'h0000_0000);
    axi_write(8'h24, 32'hffff_ffff);
    check("unmapped write resp", wrsp, 2'b00);
    axi_write(`DSOC_ADDR_IRQ_MASK, 32'h0000_0003);
    axi_read(`DSOC_ADDR_IRQ_MASK);
    check("mask", rd, 32'h0000_0003);
    @(posedge clk);
    pll_lock_detect <= 1'b1;
    repeat (5) @(negedge clk);
    check("early lock", pads.lock_n, 1'b1);
    wait_lock;
    check("driven", {pads.word_oe_n, pads.clock_oe_n}, 2'b00);
    repeat (2) @(negedge clk);
    check("irq gained", irq, 1'b1);
    axi_read(`DSOC_ADDR_IRQ_STATUS);
    check("gained", rd[1:0], 2'b01);
    repeat (2) @(negedge clk);
    check("irq clear", irq, 1'b0);
    for (int s = 1; s >= 0; s--) begin
      @(posedge clk);
      recovered_edge_select <= s[0];
      repeat (3) @(posedge clk);
      send_word(s[0] ? 10'h3ff : 10'h000);
      send_word(s[0] ? 10'h155 : 10'h2aa);
    end
    axi_read(`DSOC_ADDR_WORD_COUNT);
    check("count", rd, 32'h0000_0004);
    axi_read(`DSOC_ADDR_STATUS);
    check("status", rd, 32'h0000_0005);
    @(posedge clk);
    output_enable_n <= 1'b1;
    @(negedge clk);
    check("oe off", {pads.word_oe_n, pads.clock_oe_n, pads.lock_oe_n,
      pads.lock_n}, 4'b1100);
    axi_read(`DSOC_ADDR_STATUS);
    check("status oe off", rd, 32'h0000_0001);
    @(posedge clk);
    output_enable_n <= 1'b0;
    axi_write(`DSOC_ADDR_IRQ_MASK, 32'h0000_0000);
    @(posedge clk);
    pll_lock_detect <= 1'b0;
    repeat (2) @(negedge clk);
    check("lost", {pads.lock_n, pads.word_oe_n, pads.clock_oe_n,
      pads.lock_oe_n}, 4'b1110);
    last_clk = pads.clock;
    @(posedge clk);
    word_strobe <= 1'b1;
    word_in <= 10'h0f0;
    @(posedge clk);
    word_strobe <= 1'b0;
    repeat (2) @(negedge clk);
    check("clock still", pads.clock, last_clk);
    check("word held", pads.word, 10'h2aa);
    check("irq masked", irq, 1'b0);
    axi_read(`DSOC_ADDR_WORD_COUNT);
    check("count held", rd, 32'h0000_0004);
    axi_write(`DSOC_ADDR_IRQ_MASK, 32'h0000_0002);
    repeat (2) @(negedge clk);
    check("irq lost", irq, 1'b1);
    axi_read(`DSOC_ADDR_IRQ_STATUS);
    check("lost bit", rd[1:0], 2'b10);
    @(posedge clk);
    pll_lock_detect <= 1'b1;
    wait_lock;
    axi_write(`DSOC_ADDR_IRQ_MASK, 32'h0000_0004);
    for (int e = 0; e < 2; e++) begin
      @(posedge clk);
      output_enable_n <= e[0];
      sleep_request_n <= 1'b0;
      repeat (2) @(negedge clk);
      check("sleep", {pads.lock_oe_n, pads.word_oe_n, pads.clock_oe_n,
        pll_enable, pll_reference_gated, irq}, 6'b111001);
      @(posedge clk);
      sleep_request_n <= 1'b1;
      @(negedge clk);
      check("wake ref", pll_reference_gated, pll_reference_clock);
      @(negedge clk);
      check("wake ref next", pll_reference_gated, pll_reference_clock);
      wait_lock;
    end
    @(posedge clk);
    output_enable_n <= 1'b0;
    axi_read(`DSOC_ADDR_IRQ_STATUS);
    check("sleep bit", rd[2], 1'b1);
    axi_write(`DSOC_ADDR_CTRL, 32'h0000_0001);
    @(negedge clk);
    check("force sleep", {pll_enable, pads.lock_oe_n}, 2'b01);
    axi_read(`DSOC_ADDR_STATUS);
    check("sleeping", rd[1], 1'b1);
    axi_write(`DSOC_ADDR_CTRL, 32'h0000_0000);
    wait_lock;
    @(posedge clk);
    tap_driven <= 3'b000;
    @(negedge clk);
    check("tap free", {tap.tdi, tap.tms, tap.trst_n}, 3'b111);
    @(posedge clk);
    tap_driven <= 3'b111;
    tap_in <= 3'b110;
    @(negedge clk);
    check("tap driven", {tap.tdi, tap.tms, tap.trst_n}, 3'b011);
    tally_and_finish;
  end
endmodule
